// ### logic/osp_pkg.sv
// Package for the one-shot pulse pair: register map, fields, reset values.
// Assumes a 16-bit plain register port and a single 250 MHz clock.
`default_nettype none
package osp_pkg;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          AW            = 6;
  localparam int          DW            = 16;
  localparam int          PSC_W         = 4;
  localparam int          CH_W          = 3;
  // Register byte offsets
  localparam logic [5:0]  OFS_CTRL      = 6'h00;
  localparam logic [5:0]  OFS_TRIG      = 6'h04;
  localparam logic [5:0]  OFS_STAT      = 6'h08;
  localparam logic [5:0]  OFS_MODE      = 6'h0c;
  localparam logic [5:0]  OFS_MDATA     = 6'h10;
  localparam logic [5:0]  OFS_SDATA     = 6'h14;
  localparam logic [5:0]  OFS_MCNT      = 6'h18;
  localparam logic [5:0]  OFS_SCNT      = 6'h1c;
  localparam logic [5:0]  OFS_PSC       = 6'h20;
  // CTRL
  localparam int          B_PWR         = 0;
  // TRIG (write only, self clearing)
  localparam int          B_MSTART      = 0;
  localparam int          B_SSTART      = 1;
  localparam int          B_MSTOP       = 2;
  localparam int          B_SSTOP       = 3;
  // STAT
  localparam int          B_MRUN        = 0;
  localparam int          B_SRUN        = 1;
  localparam int          B_MWAIT       = 2;
  localparam int          B_PULSE       = 3;
  localparam int          B_PAIROK      = 4;
  // MODE
  localparam int          B_ESEL_LO     = 0;
  localparam int          B_ESEL_HI     = 1;
  localparam int          B_MSEL        = 2;
  localparam int          B_OMODE       = 3;
  localparam int          B_OLVL        = 4;
  localparam int          B_OEN         = 5;
  localparam int          B_OVAL        = 6;
  localparam int          F_MCH_LO      = 8;
  localparam int          F_SCH_LO      = 12;
  localparam logic [15:0] MODE_RST      = 16'h0000;
  localparam logic [15:0] DATA_RST      = 16'hffff;
  localparam logic [15:0] CNT_RST       = 16'hffff;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [2:0]  CH_MAX        = 3'h7;
  localparam logic [1:0]  ESEL_FALL     = 2'h0;
  localparam logic [1:0]  ESEL_RISE     = 2'h1;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_WAIT = 4'b0010,
    M_LOAD = 4'b0100,
    M_CNT  = 4'b1000
  } osp_mst_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WAIT = 4'b0010,
    S_LOAD = 4'b0100,
    S_CNT  = 4'b1000
  } osp_slv_t;
endpackage
`default_nettype wire

// ### logic/osp_sync.sv
// Three-stage input synchroniser with edge pulses for the trigger pin.
// Assumes the pin is asynchronous to mclk; a change counts once the
// second and third stages agree.
`default_nettype none
module osp_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accepted level moves only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      lvl_r <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2_r == s3_r && s3_r != lvl_r) begin
        lvl_r <= s3_r;
        rise  <= s3_r;
        fall  <= ~s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/osp_top.sv
// One-shot pulse pair: master delay channel and slave width channel.
// Assumes a plain register port on mclk; trigger pin is asynchronous.
//
// How it works
// [RQ1] Delay from trigger to pulse is (master data + 2) count clocks.
// [RQ2] Pulse width equals slave data times the count clock period.
// [RQ3] Master is one-count; a start trigger loads master data into its count.
// [RQ4] Master counts down per tick; at zero it fires and waits for a trigger.
// [RQ5] Slave is one-count, started by master completion, loads slave data.
// [RQ6] Slave counts down per tick; at zero it fires and waits for master.
// [RQ7] Pulse goes active one tick after master fires, inactive at slave zero.
// [RQ8] Writing the master start bit while running is also a trigger.
// [RQ9] Software rewrites each data register only after that channel fires.
// [RQ10] Master channel is 0, 2, 4 or 6; slave above it and at most 7.
// [RQ11] Both start bits together self clear, set run, master awaits trigger.
// [RQ12] Software never uses the slave start bit as a trigger while running.
// [RQ13] While running only the master edge select bits may change.
// [RQ14] Both stop bits clear run status, freeze counts, hold the output.
// [RQ15] Software sets output mode, level and value, then output enable.
// [RQ16] With output enable clear, the pin follows the written output value.
// [RQ17] Power enable clear resets everything, value bit 0, pin to port.
// [RQ18] Power enable clear stops the count clock and blocks register writes.
// [RQ19] Both count registers read back at any time.
// [RQ20] Software sets master select for master channels 2, 4 or 6.
// [RQ21] Software programs the prescaler before configuring the channels.
// [RQ22] Counts and data are 16 bits; zero compare uses all 16 bits.
`default_nettype none
module osp_top
  import osp_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [DW-1:0] rdata,
  input  wire logic          trig_pin,
  output logic               slave_pulse_output,
  output logic               pulse_pin_timer_sel,
  output logic               master_done_irq,
  output logic               slave_done_irq
);

  // Decrement used by both channels
  function automatic logic [DW-1:0] dec16(input logic [DW-1:0] v);
    dec16 = v - CNT_ONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic            unit_power_enable_r;
  logic [DW-1:0]   mode_r;
  logic [DW-1:0]   master_data_reg_r;
  logic [DW-1:0]   slave_data_reg_r;
  logic [DW-1:0]   master_count_reg_r;
  logic [DW-1:0]   slave_count_reg_r;
  logic [PSC_W-1:0] prescaler_select_reg_r;
  logic [DW-1:0]   psc_cnt_r;
  logic            master_run_status_r;
  logic            slave_run_status_r;
  logic            pulse_act_r;
  logic            out_val_r;
  osp_mst_t        mst_r;
  osp_slv_t        slv_r;

  logic            wr_ok;
  logic            trig_wr;
  logic            master_start_bit;
  logic            slave_start_bit;
  logic            master_stop_bit;
  logic            slave_stop_bit;
  logic            start_pair;
  logic            stop_pair;
  logic [CH_W-1:0] mch;
  logic [CH_W-1:0] sch;
  logic            pair_ok;
  logic            tick;
  logic [DW-1:0]   psc_mask;
  logic            pin_rise;
  logic            pin_fall;
  logic            pin_edge;
  logic            trig;
  logic            m_fire;
  logic            s_fire;
  logic            s_load;
  logic            timer_out;

  // Writes are ignored while the unit is powered off, except power itself
  assign wr_ok   = wr & unit_power_enable_r;                      // RQ18
  assign trig_wr = wr_ok & (addr == OFS_TRIG);

  // Trigger bits exist only for the write cycle, so they read back as 0
  assign master_start_bit = trig_wr & wdata[B_MSTART];            // RQ11
  assign slave_start_bit  = trig_wr & wdata[B_SSTART];
  assign master_stop_bit  = trig_wr & wdata[B_MSTOP];
  assign slave_stop_bit   = trig_wr & wdata[B_SSTOP];
  assign start_pair = master_start_bit & slave_start_bit;         // RQ11
  assign stop_pair  = master_stop_bit | slave_stop_bit;           // RQ14

  // Pair legality: even master, slave above it, master select beyond ch 0
  assign mch = mode_r[F_MCH_LO +: CH_W];
  assign sch = mode_r[F_SCH_LO +: CH_W];
  assign pair_ok = ~mch[0] & (sch > mch) & (sch <= CH_MAX)
                 & ((mch == '0) | mode_r[B_MSEL]);                // RQ10

  always_ff @(posedge mclk) begin
    if (rst) begin
      unit_power_enable_r <= 1'b0;
    end else if (wr && addr == OFS_CTRL) begin
      unit_power_enable_r <= wdata[B_PWR];                        // RQ18
    end
  end

  // Configuration registers; all held at reset values while power is off
  always_ff @(posedge mclk) begin
    if (rst || !unit_power_enable_r) begin
      mode_r                 <= MODE_RST;                         // RQ17
      master_data_reg_r      <= DATA_RST;
      slave_data_reg_r       <= DATA_RST;
      prescaler_select_reg_r <= '0;
    end else if (wr_ok) begin
      case (addr)
        OFS_MODE:  mode_r                 <= wdata;
        OFS_MDATA: master_data_reg_r      <= wdata;               // RQ22
        OFS_SDATA: slave_data_reg_r       <= wdata;               // RQ22
        OFS_PSC:   prescaler_select_reg_r <= wdata[PSC_W-1:0];
        default:   ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count clock prescaler

  assign psc_mask = DW'((17'h1 << prescaler_select_reg_r) - 17'h1);
  // Count clock stops with power off
  assign tick = unit_power_enable_r
              & ((psc_cnt_r & psc_mask) == psc_mask);             // RQ18

  always_ff @(posedge mclk) begin
    if (rst || !unit_power_enable_r) begin
      psc_cnt_r <= '0;
    end else begin
      psc_cnt_r <= psc_cnt_r + CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger detection

  osp_sync u_sync (
    .mclk (mclk),
    .rst  (rst),
    .pin  (trig_pin),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  // Edge select: 00 falling, 01 rising, otherwise both edges
  always_comb begin
    case (mode_r[B_ESEL_HI:B_ESEL_LO])
      ESEL_FALL: pin_edge = pin_fall;
      ESEL_RISE: pin_edge = pin_rise;
      default:   pin_edge = pin_rise | pin_fall;
    endcase
  end

  // Slave start bit alone is no trigger
  assign trig = pair_ok & master_run_status_r
              & (pin_edge | (master_start_bit & ~start_pair));    // RQ8

  ////////////////////////////////////////////////////////////////////////////
  // Run status

  always_ff @(posedge mclk) begin
    if (rst || !unit_power_enable_r) begin
      master_run_status_r <= 1'b0;
      slave_run_status_r  <= 1'b0;
    end else if (stop_pair) begin
      master_run_status_r <= 1'b0;                                // RQ14
      slave_run_status_r  <= 1'b0;                                // RQ14
    end else if (start_pair && pair_ok) begin
      master_run_status_r <= 1'b1;                                // RQ11
      slave_run_status_r  <= 1'b1;                                // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master delay channel

  // Zero reached on the load tick for data 0, else when count leaves 1
  assign m_fire = tick & (((mst_r == M_LOAD)
                           && (master_data_reg_r == CNT_ZERO))
                          || ((mst_r == M_CNT)
                              && (master_count_reg_r == CNT_ONE))); // RQ4

  always_ff @(posedge mclk) begin
    if (rst || !unit_power_enable_r) begin
      mst_r              <= M_IDLE;
      master_count_reg_r <= CNT_RST;
    end else if (stop_pair) begin
      mst_r <= M_IDLE;                                            // RQ14
    end else if (start_pair && pair_ok) begin
      mst_r <= M_WAIT;                                            // RQ11
    end else begin
      case (mst_r)
        M_IDLE: mst_r <= M_IDLE;
        M_WAIT: begin
          if (trig) begin
            mst_r <= M_LOAD;                                      // RQ3
          end
        end
        M_LOAD: begin
          if (tick) begin
            master_count_reg_r <= master_data_reg_r;              // RQ3
            mst_r <= m_fire ? M_WAIT : M_CNT;
          end
        end
        M_CNT: begin
          if (tick) begin
            master_count_reg_r <= dec16(master_count_reg_r);      // RQ4
            if (m_fire) begin
              mst_r <= M_WAIT;                                    // RQ4
            end
          end
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave width channel

  assign s_load = tick & (slv_r == S_LOAD);
  assign s_fire = tick & (((slv_r == S_LOAD)
                           && (slave_data_reg_r == CNT_ZERO))
                          || ((slv_r == S_CNT)
                              && (slave_count_reg_r == CNT_ONE))); // RQ6

  always_ff @(posedge mclk) begin
    if (rst || !unit_power_enable_r) begin
      slv_r             <= S_IDLE;
      slave_count_reg_r <= CNT_RST;
    end else if (stop_pair) begin
      slv_r <= S_IDLE;                                            // RQ14
    end else if (start_pair && pair_ok) begin
      slv_r <= S_WAIT;
    end else begin
      case (slv_r)
        S_IDLE: slv_r <= S_IDLE;
        S_WAIT: begin
          if (m_fire) begin
            slv_r <= S_LOAD;                                      // RQ5
          end
        end
        S_LOAD: begin
          if (tick) begin
            slave_count_reg_r <= slave_data_reg_r;                // RQ5
            slv_r <= s_fire ? S_WAIT : S_CNT;
          end
        end
        S_CNT: begin
          if (tick) begin
            slave_count_reg_r <= dec16(slave_count_reg_r);        // RQ6
            if (s_fire) begin
              slv_r <= S_WAIT;                                    // RQ6
            end
          end
        end
        default: slv_r <= S_IDLE;
      endcase
    end
  end

  // Pulse spans slave load tick to slave zero tick: data count clocks
  always_ff @(posedge mclk) begin
    if (rst || !unit_power_enable_r) begin
      pulse_act_r <= 1'b0;
    end else if (s_fire) begin
      pulse_act_r <= 1'b0;                                        // RQ7
    end else if (s_load) begin
      pulse_act_r <= 1'b1;                                        // RQ1 RQ2 RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output value bit and pin

  // Level bit set means active low
  // Drop on the zero tick itself, so the pin is high for exactly data ticks
  assign timer_out = ((pulse_act_r | s_load) & ~s_fire) ^ mode_r[B_OLVL];

  // Timer owns the value while enabled in slave output mode; a stop freezes it
  always_ff @(posedge mclk) begin
    if (rst || !unit_power_enable_r) begin
      out_val_r <= 1'b0;                                          // RQ17
    end else if (wr_ok && addr == OFS_MODE && !wdata[B_OEN]) begin
      out_val_r <= wdata[B_OVAL];                                 // RQ16
    end else if (mode_r[B_OEN] && mode_r[B_OMODE]
                 && slave_run_status_r && !stop_pair) begin
      out_val_r <= timer_out;                                     // RQ7
    end
  end

  assign slave_pulse_output = out_val_r;

  // Pin returns to port function with power off
  always_ff @(posedge mclk) begin
    if (rst) begin
      pulse_pin_timer_sel <= 1'b0;
    end else begin
      pulse_pin_timer_sel <= unit_power_enable_r;                 // RQ17
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      master_done_irq <= 1'b0;
      slave_done_irq  <= 1'b0;
    end else begin
      master_done_irq <= m_fire & ~stop_pair;                     // RQ4
      slave_done_irq  <= s_fire & ~stop_pair;                     // RQ6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        OFS_CTRL:  rdata <= DW'(unit_power_enable_r);
        OFS_STAT:  rdata <= DW'({pair_ok, out_val_r, (mst_r == M_WAIT),
                                 slave_run_status_r, master_run_status_r});
        OFS_MODE:  rdata <= {mode_r[DW-1:B_OVAL+1], out_val_r,
                             mode_r[B_OVAL-1:0]};
        OFS_MDATA: rdata <= master_data_reg_r;
        OFS_SDATA: rdata <= slave_data_reg_r;
        OFS_MCNT:  rdata <= master_count_reg_r;                   // RQ19
        OFS_SCNT:  rdata <= slave_count_reg_r;                    // RQ19
        OFS_PSC:   rdata <= DW'(prescaler_select_reg_r);
        default:   rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// ### tb/osp_far_end.sv
// Far side of the pulse pair: a trigger source on the input pin.
// Assumes the bench pulses fire for one mclk cycle to ask for an edge.
`default_nettype none
module osp_far_end (
  input  wire logic mclk,
  input  wire logic fire,
  output var  logic trig_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial trig_pin = 1'b0;
  // Rising edge off the clock grid, held for six cycles, then idle low
  always @(posedge mclk) begin
    if (fire) begin
      #1.3 trig_pin = 1'b1;
      repeat (6) @(posedge mclk);
      #1.3 trig_pin = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/osp_monitor.sv
// Port checker for osp_top, attached by bind.
// Assumes software state is shadowed from the register port writes.
`default_nettype none
module osp_monitor
  import osp_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic [DW-1:0] rdata,
  input wire logic          trig_pin,
  input wire logic          slave_pulse_output,
  input wire logic          pulse_pin_timer_sel,
  input wire logic          master_done_irq,
  input wire logic          slave_done_irq
);
  logic             pwr_r;
  logic             pend_r;
  logic [DW-1:0]    mode_r;
  logic [DW-1:0]    mdata_r;
  logic [DW-1:0]    sdata_r;
  logic [DW-1:0]    dly_r;
  logic [DW-1:0]    hi_r;
  logic [PSC_W-1:0] psc_r;
  logic             trig_w;
  logic             go;
  assign trig_w = wr && pwr_r && addr == OFS_TRIG;
  assign go = psc_r == '0 && mode_r[B_OEN] && !mode_r[B_OLVL];
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (rst)
      pwr_r <= 1'b0;
    else if (wr && addr == OFS_CTRL)
      pwr_r <= wdata[B_PWR];
  end
  always_ff @(posedge mclk) begin
    if (rst || !pwr_r) begin
      mode_r  <= MODE_RST;
      mdata_r <= DATA_RST;
      sdata_r <= DATA_RST;
      psc_r   <= '0;
    end else if (wr) begin
      case (addr)
        OFS_MODE:  mode_r <= wdata;
        OFS_MDATA: mdata_r <= wdata;
        OFS_SDATA: sdata_r <= wdata;
        OFS_PSC:   psc_r <= wdata[PSC_W-1:0];
        default: ;
      endcase
    end
  end
  // Cycles since a software trigger that found the master idle
  always_ff @(posedge mclk) begin
    if (rst || !pwr_r || master_done_irq || (trig_w && wdata[B_MSTOP]))
      pend_r <= 1'b0;
    else if (trig_w && wdata[3:0] == 4'h1)
      pend_r <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (trig_w && wdata[3:0] == 4'h1 && !pend_r)
      dly_r <= 16'h0001;
    else
      dly_r <= dly_r + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (rst || !slave_pulse_output)
      hi_r <= '0;
    else
      hi_r <= hi_r + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_master_delay: assert property (
    master_done_irq && pend_r && go |-> dly_r == mdata_r + 16'h0002)
    else $error("master delay wrong");
  a_pulse_rise: assert property (
    master_done_irq && go && sdata_r != CNT_ZERO
    |=> $rose(slave_pulse_output))
    else $error("pulse did not start after master event");
  a_width_end: assert property (
    $fell(slave_pulse_output) && go |-> hi_r == sdata_r && slave_done_irq)
    else $error("pulse width or slave event wrong");
  a_mirq_single: assert property (
    master_done_irq |=> !master_done_irq)
    else $error("master event longer than one cycle");
  a_sirq_single: assert property (
    slave_done_irq |=> !slave_done_irq)
    else $error("slave event longer than one cycle");
  a_off_clears: assert property (
    wr && addr == OFS_CTRL && !wdata[B_PWR]
    |-> ##2 (!pulse_pin_timer_sel && !slave_pulse_output))
    else $error("power off left pin driven");
  a_on_selects: assert property (
    wr && addr == OFS_CTRL && wdata[B_PWR] |-> ##2 pulse_pin_timer_sel)
    else $error("power on did not take pin");
  a_stop_holds: assert property (
    trig_w && wdata[B_MSTOP] && wdata[B_SSTOP] |-> ##2
    ($stable(slave_pulse_output) && !master_done_irq && !slave_done_irq)[*4])
    else $error("stop did not freeze");
  a_oen_follow: assert property (
    wr && pwr_r && addr == OFS_MODE && !wdata[B_OEN]
    |-> ##2 slave_pulse_output == $past(wdata[B_OVAL], 2))
    else $error("pin not following value bit");
endmodule
bind osp_top osp_monitor u_mon (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .trig_pin(trig_pin),
  .slave_pulse_output(slave_pulse_output),
  .pulse_pin_timer_sel(pulse_pin_timer_sel),
  .master_done_irq(master_done_irq), .slave_done_irq(slave_done_irq));
`default_nettype wire

// ### tb/osp_tb.sv
// Self-checking bench for osp_top with a pin trigger source.
// Assumes a 250 MHz mclk and the register map of osp_pkg.
`default_nettype none
module testbench
  import osp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic          rd_q = 1'b0;
  logic          fire = 1'b0;
  logic          meas = 1'b1;
  logic [DW-1:0] rdata;
  logic          trig_pin;
  logic          slave_pulse_output;
  logic          pulse_pin_timer_sel;
  logic          master_done_irq;
  logic          slave_done_irq;
  logic [DW-1:0] exp_q[$];
  logic [DW-1:0] d;
  logic [DW-1:0] w;
  logic [DW-1:0] m;
  logic [DW-1:0] md[4];
  logic [DW-1:0] st[4];
  int            wq[$];
  int            miscompares = 0;
  int            compares = 0;
  int            seed;
  int            hcnt = 0;
  int            cyc = 0;
  int            i;
  int            p;
  always #2 mclk = ~mclk;
  osp_top dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trig_pin(trig_pin),
    .slave_pulse_output(slave_pulse_output),
    .pulse_pin_timer_sel(pulse_pin_timer_sel),
    .master_done_irq(master_done_irq), .slave_done_irq(slave_done_irq));
  osp_far_end u_far (.mclk(mclk), .fire(fire), .trig_pin(trig_pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bad(input string s);
    miscompares++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(input logic got, input logic e, input string s);
    @(negedge mclk);
    compares++;
    if (got !== e)
      bad(s);
  endtask
  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [AW-1:0] a, input logic [DW-1:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Waits for the pulse (1) or the slave event (0), bounded
  task automatic wait_sig(input logic pick);
    int k;
    k = 0;
    while ((pick ? slave_pulse_output : slave_done_irq) !== 1'b1 && k < 4000)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 4000)
      bad("wait expired");
  endtask
  function automatic logic [DW-1:0] mode_of(input int mc, sc, ms);
    mode_of = DW'(mc << F_MCH_LO) | DW'(sc << F_SCH_LO) | DW'(ms << B_MSEL)
            | (16'h1 << B_OMODE) | (16'h1 << B_OEN) | DW'(ESEL_RISE);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Read data and pulse width watcher
  always @(posedge mclk) begin
    rd_q <= rd;
    if (rd_q && exp_q.size() > 0) begin
      compares++;
      if (rdata !== exp_q[0])
        bad("read data");
      void'(exp_q.pop_front());
    end
    if (slave_pulse_output === 1'b1 && meas)
      hcnt++;
    else if (hcnt != 0) begin
      compares++;
      if (wq.size() == 0 || wq[0] != hcnt)
        bad("pulse width");
      if (wq.size() > 0)
        void'(wq.pop_front());
      hcnt = 0;
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad("timeout");
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 59;
    md = '{mode_of(1, 2, 0), mode_of(2, 2, 1), mode_of(2, 3, 0),
           mode_of(6, 7, 1)};
    st = '{16'h0000, 16'h0000, 16'h0000, 16'h0017};
    idle(16);
    rst <= 1'b0;
    wreg(OFS_MDATA, 16'h0005);
    rreg(OFS_MDATA, DATA_RST);
    chk(pulse_pin_timer_sel, 1'b0, "pin owned at power off");
    wreg(OFS_CTRL, 16'h0001);
    rreg(OFS_MCNT, CNT_RST);
    rreg(OFS_SCNT, CNT_RST);
    rreg(OFS_MODE, MODE_RST);
    rreg(6'h3c, 16'h0000);
    rreg(OFS_TRIG, 16'h0000);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      wreg(OFS_MODE, md[i]);
      wreg(OFS_TRIG, 16'h0003);
      rreg(OFS_STAT, st[i]);
      wreg(OFS_TRIG, 16'h000c);
      idle(6);
    end
    $display("test pairing done");
    wreg(OFS_MODE, mode_of(0, 1, 0));
    for (i = 0; i < 6; i++) begin
      d = 16'($random(seed)) & 16'h001f;
      w = 16'h0001 + (16'($random(seed)) & 16'h000f);
      if (i == 0) begin
        d = 16'h0000;
        w = 16'h0001;
      end
      if (i == 1)
        d = 16'h0014;
      p = (i < 4) ? 0 : i - 3;
      wreg(OFS_TRIG, 16'h000c);
      idle(6);
      wreg(OFS_PSC, DW'(p));
      wreg(OFS_MDATA, d);
      wreg(OFS_SDATA, w);
      wreg(OFS_TRIG, 16'h0003);
      rreg(OFS_STAT, 16'h0017);
      wq.push_back(int'(w) << p);
      wreg(OFS_TRIG, 16'h0001);
      if (i == 1)
        wreg(OFS_TRIG, 16'h0001);
      wait_sig(1'b0);
      rreg(OFS_MCNT, CNT_ZERO);
      rreg(OFS_SCNT, CNT_ZERO);
    end
    $display("test software trigger done");
    wreg(OFS_TRIG, 16'h000c);
    idle(6);
    wreg(OFS_PSC, 16'h0000);
    wreg(OFS_MDATA, 16'h0003);
    wreg(OFS_SDATA, 16'h0005);
    wreg(OFS_TRIG, 16'h0003);
    wq.push_back(5);
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    wait_sig(1'b0);
    $display("test pin trigger done");
    meas = 1'b0;
    wreg(OFS_SDATA, 16'h0040);
    wreg(OFS_TRIG, 16'h0001);
    wait_sig(1'b1);
    wreg(OFS_TRIG, 16'h000c);
    idle(4);
    chk(slave_pulse_output, 1'b1, "output not held");
    rreg(OFS_STAT, 16'h0018);
    m = mode_of(0, 1, 0) & ~(16'h1 << B_OEN);
    wreg(OFS_MODE, m);
    idle(2);
    chk(slave_pulse_output, 1'b0, "value bit low");
    wreg(OFS_MODE, m | (16'h1 << B_OVAL));
    idle(2);
    chk(slave_pulse_output, 1'b1, "value bit high");
    $display("test stop and value done");
    wreg(OFS_CTRL, 16'h0000);
    idle(2);
    chk(pulse_pin_timer_sel, 1'b0, "pin still owned");
    chk(slave_pulse_output, 1'b0, "value bit kept");
    rreg(OFS_MODE, MODE_RST);
    rreg(OFS_SCNT, CNT_RST);
    idle(3);
    chk(exp_q.size() == 0 && wq.size() == 0, 1'b1, "results missing");
    $display("test power off done");
    print_verdict();
  end
endmodule
`default_nettype wire
